// File: rtl/comparator_event_sense_cfg.svh
// Offsets, field positions and reset values of the comparator event block.
// Assumes byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef COMPARATOR_EVENT_SENSE_CFG_SVH
`define COMPARATOR_EVENT_SENSE_CFG_SVH

`define CES_STAT_OFF 8'h20
`define CES_CTRL_OFF 8'h24
`define CES_ISTAT_OFF 8'h28
`define CES_IMASK_OFF 8'h2C

`define CES_CTRL_RST 12'h000
`define CES_CTRL_WMASK 12'h8FE
`define CES_IRQ_RST 2'h0

`define CES_F_INV 1
`define CES_F_IRQ_SENSE_SELECT 2
`define CES_F_ILVL 4
`define CES_F_ADC_TRIGGER_SENSE_SELECT 5
`define CES_F_TLVL 7
`define CES_F_ADC_TRIGGER_OUTPUT_GATE 11
`define CES_F_OVAL 1

`define CES_RESP_OKAY 2'h0
`define CES_RESP_SLVERR 2'h2

`endif

// File: rtl/comparator_event_sense_pkg.sv
// Types shared by the comparator event block and its sense units.
// Assumes nothing of its surroundings.
package comparator_event_sense_pkg;

	typedef enum logic [1:0] {
		SENSE_LEVEL = 2'h0,
		SENSE_FALL = 2'h1,
		SENSE_RISE = 2'h2,
		SENSE_EITHER = 2'h3
	} sense_mode_type;

endpackage

// File: rtl/sense_if.sv
// Carrier between the top block and one event sense unit.
// Assumes the conditioned level and its previous value share one clock.
`timescale 1ns/1ps
interface sense_if;
	import comparator_event_sense_pkg::*;

	logic now_level;
	logic prev_level;
	sense_mode_type mode;
	logic active_level;
	logic event_hit;

	modport ctrl (
		output now_level,
		output prev_level,
		output mode,
		output active_level,
		input event_hit
	);

	modport unit (
		input now_level,
		input prev_level,
		input mode,
		input active_level,
		output event_hit
	);

endinterface

// File: rtl/event_sense.sv
// One sense unit: level or edge qualification of the conditioned output.
// Assumes the previous level is the current one delayed by one clock.
`timescale 1ns/1ps
module event_sense
	import comparator_event_sense_pkg::*;
(
	sense_if.unit port
);

	wire rise_w = port.now_level & ~port.prev_level;
	wire fall_w = ~port.now_level & port.prev_level;
	wire level_w = (port.now_level == port.active_level);

	// Combinational on purpose: the top registers the result once
	assign port.event_hit = (port.mode == SENSE_LEVEL) ? level_w :
		(port.mode == SENSE_FALL) ? fall_w :
		(port.mode == SENSE_RISE) ? rise_w :
		(rise_w | fall_w);

endmodule

// File: rtl/comparator_event_sense.sv
// Comparator output conditioning with interrupt and converter trigger.
// Assumes an AXI4-Lite master, one clock and a comparator level input.
`timescale 1ns/1ps
`include "comparator_event_sense_cfg.svh"
module comparator_event_sense
	import comparator_event_sense_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic comp_level_in,
	output logic adc_trigger_out,
	output logic irq_out,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);

	localparam int WA = ADDR_W - 2;

	logic [11:0] ctrl_q;
	logic [11:0] ctrl_d;
	logic [1:0] irq_status_q;
	logic [1:0] irq_status_d;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_mask_d;
	logic sync1_q;
	logic sync2_q;
	logic cond_prev_q;
	logic adc_trigger_q;
	logic irq_q;

	logic aw_have_q;
	logic aw_have_d;
	logic [ADDR_W-1:0] aw_addr_q;
	logic w_have_q;
	logic w_have_d;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic rd_ctrl_q;

	// Named control fields
	wire output_invert = ctrl_q[`CES_F_INV];
	wire [1:0] irq_sense_select = ctrl_q[`CES_F_IRQ_SENSE_SELECT +: 2];
	wire irq_level_value = ctrl_q[`CES_F_ILVL];
	wire [1:0] adc_trigger_sense_select = ctrl_q[`CES_F_ADC_TRIGGER_SENSE_SELECT +: 2];
	wire adc_trigger_level_value = ctrl_q[`CES_F_TLVL];
	wire adc_trigger_output_gate = ctrl_q[`CES_F_ADC_TRIGGER_OUTPUT_GATE];

	// Comparator conditioning
	wire cond_w = sync2_q ^ output_invert;
	wire rise_w = cond_w & ~cond_prev_q;
	wire fall_w = ~cond_w & cond_prev_q;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			cond_prev_q <= 1'b0;
		end else begin
			sync1_q <= comp_level_in;
			sync2_q <= sync1_q;
			cond_prev_q <= cond_w;
		end
	end

	// Channel 0 is the interrupt path, channel 1 the converter trigger
	wire [1:0] mode_w [2];
	wire level_w [2];
	wire event_w [2];

	assign mode_w[0] = irq_sense_select;
	assign mode_w[1] = adc_trigger_sense_select;
	assign level_w[0] = irq_level_value;
	assign level_w[1] = adc_trigger_level_value;

	sense_if sif [2] ();

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sense
			assign sif[g].now_level = cond_w;
			assign sif[g].prev_level = cond_prev_q;
			assign sif[g].mode = sense_mode_type'(mode_w[g]);
			assign sif[g].active_level = level_w[g];
			assign event_w[g] = sif[g].event_hit;
			event_sense u_sense (
				.port(sif[g].unit)
			);
		end
	endgenerate

	wire trig_fire_w = event_w[1] & adc_trigger_output_gate;
	wire [1:0] irq_set_w = {trig_fire_w, event_w[0]};

	// Write channel
	wire aw_take_w = s_axi_awvalid_in & awready_q;
	wire w_take_w = s_axi_wvalid_in & wready_q;
	wire do_write_w = aw_have_q & w_have_q & ~bvalid_q;
	wire [WA-1:0] aw_idx_w = aw_addr_q[ADDR_W-1:2];
	wire wr_stat_w = aw_idx_w == WA'(`CES_STAT_OFF >> 2);
	wire wr_ctrl_w = aw_idx_w == WA'(`CES_CTRL_OFF >> 2);
	wire wr_istat_w = aw_idx_w == WA'(`CES_ISTAT_OFF >> 2);
	wire wr_imask_w = aw_idx_w == WA'(`CES_IMASK_OFF >> 2);
	wire wr_hit_w = wr_stat_w | wr_ctrl_w | wr_istat_w | wr_imask_w;
	wire [31:0] bmask_w = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [11:0] ctrl_wm_w = `CES_CTRL_WMASK & bmask_w[11:0];
	wire [1:0] irq_wm_w = w_data_q[1:0] & bmask_w[1:0];

	// Hardware set wins over a software clear in the same cycle
	wire [1:0] irq_clr_w = (do_write_w & wr_istat_w) ? irq_wm_w : 2'h0;

	assign ctrl_d = (do_write_w & wr_ctrl_w) ?
		((ctrl_q & ~ctrl_wm_w) | (w_data_q[11:0] & ctrl_wm_w)) : ctrl_q;
	assign irq_mask_d = (do_write_w & wr_imask_w) ?
		((irq_mask_q & ~bmask_w[1:0]) | irq_wm_w) : irq_mask_q;
	assign irq_status_d = (irq_status_q & ~irq_clr_w) | irq_set_w;
	assign aw_have_d = aw_take_w | (aw_have_q & ~do_write_w);
	assign w_have_d = w_take_w | (w_have_q & ~do_write_w);
	assign bvalid_d = do_write_w | (bvalid_q & ~s_axi_bready_in);

	// Read channel
	wire ar_take_w = s_axi_arvalid_in & arready_q;
	wire [WA-1:0] ar_idx_w = s_axi_araddr_in[ADDR_W-1:2];
	wire rd_stat_w = ar_idx_w == WA'(`CES_STAT_OFF >> 2);
	wire rd_ctrl_w = ar_idx_w == WA'(`CES_CTRL_OFF >> 2);
	wire rd_istat_w = ar_idx_w == WA'(`CES_ISTAT_OFF >> 2);
	wire rd_imask_w = ar_idx_w == WA'(`CES_IMASK_OFF >> 2);
	wire rd_hit_w = rd_stat_w | rd_ctrl_w | rd_istat_w | rd_imask_w;
	wire [31:0] stat_word_w = {{30{1'b0}}, sync2_q, 1'b0};
	wire [31:0] ctrl_word_w = {{20{1'b0}}, ctrl_q[11:1], 1'b0};
	wire [31:0] rd_word_w = rd_ctrl_w ? ctrl_word_w :
		rd_stat_w ? stat_word_w :
		rd_istat_w ? {{30{1'b0}}, irq_status_q} :
		rd_imask_w ? {{30{1'b0}}, irq_mask_q} : {32{1'b0}};
	assign rvalid_d = ar_take_w | (rvalid_q & ~s_axi_rready_in);

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= `CES_CTRL_RST;
			irq_status_q <= `CES_IRQ_RST;
			irq_mask_q <= `CES_IRQ_RST;
			adc_trigger_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			irq_status_q <= irq_status_d;
			irq_mask_q <= irq_mask_d;
			adc_trigger_q <= trig_fire_w;
			irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awready_q <= ~aw_have_d;
			wready_q <= ~w_have_d;
			bvalid_q <= bvalid_d;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_addr_q <= '0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bresp_q <= `CES_RESP_OKAY;
		end else begin
			if (aw_take_w) begin
				aw_addr_q <= s_axi_awaddr_in;
			end
			if (w_take_w) begin
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
			end
			if (do_write_w) begin
				bresp_q <= wr_hit_w ? `CES_RESP_OKAY : `CES_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `CES_RESP_OKAY;
			rd_ctrl_q <= 1'b0;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take_w) begin
				rdata_q <= rd_word_w;
				rresp_q <= rd_hit_w ? `CES_RESP_OKAY : `CES_RESP_SLVERR;
				rd_ctrl_q <= rd_ctrl_w;
			end
		end
	end

	assign adc_trigger_out = adc_trigger_q;
	assign irq_out = irq_q;
	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;
	assign s_axi_rvalid_out = rvalid_q;

	// Checks on the event paths and register behaviour

	a_trig_fall_edge: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(adc_trigger_sense_select == 2'h1 && adc_trigger_output_gate
			&& cond_prev_q && !cond_w) |=> adc_trigger_out
	) else $error("falling edge did not trigger converter");

	a_trig_level_sense: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(adc_trigger_sense_select == 2'h0 && adc_trigger_output_gate
			&& cond_w != adc_trigger_level_value) |=> !adc_trigger_out
	) else $error("trigger fired at inactive level");

	a_trig_level_hold: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(adc_trigger_sense_select == 2'h0 && adc_trigger_output_gate
			&& cond_w == adc_trigger_level_value)[*3]
		|=> adc_trigger_out
	) else $error("trigger not held at active level");

	a_trig_gate_off: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		!adc_trigger_output_gate |=> !adc_trigger_out
	) else $error("trigger passed while gate off");

	a_irq_level_set: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(irq_sense_select == 2'h0 && cond_w == irq_level_value
			&& irq_mask_d[0]) |=> irq_status_q[0] ##1 irq_out
	) else $error("level interrupt not raised");

	a_irq_rise_edge: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(irq_sense_select == 2'h2 && rise_w) |=> irq_status_q[0]
	) else $error("rising edge did not set interrupt status");

	a_irq_edge_quiet: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(irq_sense_select == 2'h2 && !rise_w && !irq_status_q[0]
			&& !irq_clr_w[0]) |=> !irq_status_q[0]
	) else $error("edge mode set status without an edge");

	a_invert_path: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(output_invert && $stable(output_invert) && $rose(sync2_q))
		|-> (!cond_w && fall_w)
	) else $error("inverted input did not fall");

	a_rsvd_read_zero: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(s_axi_rvalid_out && rd_ctrl_q) |-> (s_axi_rdata_out[0] == 1'b0)
	) else $error("reserved control bit read nonzero");

	a_reset_fields: assert property (
		@(posedge core_clk_in)
		rst_in |=> (ctrl_q == `CES_CTRL_RST)
	) else $error("control not cleared by reset");

	a_edge_one_pulse: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(adc_trigger_sense_select == 2'h2 && adc_trigger_output_gate
			&& rise_w) ##1 (!rise_w && adc_trigger_sense_select == 2'h2)
		|=> !adc_trigger_out
	) else $error("edge trigger longer than one cycle");

	a_bresp_after_write: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		do_write_w |=> s_axi_bvalid_out
	) else $error("write response missing");

	a_trig_rise_edge: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(adc_trigger_sense_select == 2'h2 && adc_trigger_output_gate
			&& rise_w) |=> adc_trigger_out
	) else $error("rising edge did not trigger converter");

	a_irq_fall_edge: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(irq_sense_select == 2'h1 && fall_w) |=> irq_status_q[0]
	) else $error("falling edge did not set interrupt status");

	a_irq_level_sense: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(irq_sense_select == 2'h0 && cond_w != irq_level_value
			&& !irq_status_q[0]) |=> !irq_status_q[0]
	) else $error("level interrupt set at inactive level");

	a_irq_mask_gate: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		((irq_status_q & irq_mask_q) == 2'h0) |=> !irq_out
	) else $error("interrupt raised with no unmasked status");

	// Sticky bit must survive a clear that lands on its own event
	a_set_beats_clear: assert property (
		@(posedge core_clk_in) disable iff (rst_in)
		(irq_set_w[0] && irq_clr_w[0]) |=> irq_status_q[0]
	) else $error("clear won over a same-cycle set");

endmodule

// File: bench/comp_source_model.sv
// Partner model: comparator output source and converter trigger sink.
// Assumes one clock; the bench commands the wanted comparator level.
`timescale 1ns/1ps
module comp_source_model (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic level_cmd_in,
	input wire logic trigger_in,
	output logic comp_level_out,
	output int trig_count_out
);
	// Count trigger cycles; an edge event must add exactly one
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			comp_level_out <= 1'b0;
			trig_count_out <= 0;
		end else begin
			comp_level_out <= level_cmd_in;
			if (trigger_in)
				trig_count_out <= trig_count_out + 1;
		end
	end
endmodule

// File: bench/comparator_event_sense_tb_top.sv
// Self-checking bench for the comparator event block.
// Assumes the partner model in bench/ and the design under rtl/.
`timescale 1ns/1ps
module comparator_event_sense_tb_top;
	logic clk = 0, rst = 1, lvl_cmd = 0, comp, trig, irq;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0] bresp, rresp;
	int trig_cnt, c0, fail_count = 0, samples_checked = 0;

	always #2.5 clk = ~clk;

	comparator_event_sense comparator_event_sense_i (.core_clk_in(clk),
		.rst_in(rst), .comp_level_in(comp), .adc_trigger_out(trig),
		.irq_out(irq), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready));

	comp_source_model comp_source_model_i (.core_clk_in(clk), .rst_in(rst),
		.level_cmd_in(lvl_cmd), .trigger_in(trig), .comp_level_out(comp),
		.trig_count_out(trig_cnt));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Waits as long as the slave needs; only the watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
		check(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 0;
		end while (rvalid !== 1'b1);
		rready <= 0;
		check(rdata, exp);
		check(rresp, er);
	endtask

	// Comparator change needs a model flop, two sync flops and one more
	task automatic drive(input logic v);
		@(posedge clk);
		lvl_cmd <= v;
		repeat (8) @(posedge clk);
	endtask

	function automatic logic [31:0] ctl(input logic g, input logic tl,
		input logic [1:0] ts, input logic il, input logic [1:0] is,
		input logic inv);
		return {20'h0_0000, g, 3'h0, tl, ts, il, is, inv, 1'b0};
	endfunction

	task automatic t_regs;
		rd(8'h24, 32'h0000_0000, 2'h0);
		wr(8'h24, 32'hFFFF_FFFF, 2'h0);
		rd(8'h24, 32'h0000_08FE, 2'h0);
		wr(8'h30, 32'hFFFF_FFFF, 2'h2);
		rd(8'h30, 32'h0000_0000, 2'h2);
		wr(8'h24, 32'h0000_0000, 2'h0);
	endtask

	task automatic t_trig_edges;
		for (int m = 1; m < 4; m++) begin
			wr(8'h24, ctl(1, 0, m[1:0], 0, 0, 0), 2'h0);
			drive(0);
			c0 = trig_cnt;
			drive(1);
			check(trig_cnt - c0, m != 1);
			c0 = trig_cnt;
			drive(0);
			check(trig_cnt - c0, m != 2);
		end
		rd(8'h28, 32'h0000_0003, 2'h0);
		wr(8'h24, ctl(0, 0, 2'h3, 0, 0, 0), 2'h0);
		wr(8'h28, 32'h0000_0002, 2'h0);
		c0 = trig_cnt;
		drive(1);
		drive(0);
		check(trig_cnt - c0, 0);
		rd(8'h28, 32'h0000_0001, 2'h0);
	endtask

	task automatic t_trig_level;
		for (int tl = 0; tl < 2; tl++) begin
			for (int lv = 0; lv < 2; lv++) begin
				wr(8'h24, ctl(1, tl[0], 2'h0, 0, 0, 0), 2'h0);
				drive(lv[0]);
				check(trig, tl == lv);
			end
		end
		wr(8'h24, ctl(1, 1, 2'h0, 0, 0, 1), 2'h0);
		drive(0);
		check(trig, 1);
		rd(8'h20, 32'h0000_0000, 2'h0);
		drive(1);
		check(trig, 0);
		rd(8'h20, 32'h0000_0002, 2'h0);
	endtask

	task automatic t_irq;
		wr(8'h2C, 32'h0000_0001, 2'h0);
		for (int m = 1; m < 4; m++) begin
			wr(8'h24, ctl(0, 0, 0, 0, m[1:0], 0), 2'h0);
			drive(0);
			wr(8'h28, 32'h0000_0003, 2'h0);
			drive(1);
			rd(8'h28, m != 1, 2'h0);
			check(irq, m != 1);
			wr(8'h28, 32'h0000_0003, 2'h0);
			drive(0);
			rd(8'h28, m != 2, 2'h0);
		end
		for (int il = 0; il < 2; il++) begin
			for (int lv = 0; lv < 2; lv++) begin
				wr(8'h24, ctl(0, 0, 0, il[0], 2'h0, 0), 2'h0);
				drive(lv[0]);
				wr(8'h28, 32'h0000_0003, 2'h0);
				repeat (3) @(posedge clk);
				check(irq, il == lv);
			end
		end
		wr(8'h2C, 32'h0000_0000, 2'h0);
		repeat (3) @(posedge clk);
		check(irq, 0);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		t_regs();
		t_trig_edges();
		t_trig_level();
		t_irq();
		wrap_up();
	end

	// Whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule
